// ===== hw/pim_params.svh
`ifndef PIM_PARAMS_SVH
`define PIM_PARAMS_SVH

// Register indices; the byte address on APB is four times the index.
`define PIM_IDX_BSTAT 6'h01
`define PIM_IDX_LPABL 6'h05
`define PIM_IDX_EXPN 6'h06
`define PIM_IDX_MODE 6'h11
`define PIM_IDX_FLAGS 6'h1d
`define PIM_IDX_MASK 6'h1e

// Source positions, shared by the flag and the mask register.
`define PIM_SRC_ENERGY 7
`define PIM_SRC_NEGDONE 6
`define PIM_SRC_RFAULT 5
`define PIM_SRC_LINKDN 4
`define PIM_SRC_PACK 3
`define PIM_SRC_PDF 2
`define PIM_SRC_PAGE 1

// Field positions inside the mirrored status registers.
`define PIM_BS_NEGDONE 5
`define PIM_BS_RFAULT 4
`define PIM_BS_LINK 2
`define PIM_LP_ACK 14
`define PIM_EX_PDF 4
`define PIM_EX_PAGE 1

// Field positions inside the mode control register.
`define PIM_MD_EDPD 13
`define PIM_MD_ALT 6
`define PIM_MD_ENERGY 1

// Writable, reset and release patterns of the flag and mask registers, and the reset levels of the edge detector.
`define PIM_SRC_BITS 8'hfe
`define PIM_FLAG_RST 8'h80
`define PIM_MASK_RST 8'h00
`define PIM_ACT_RST 8'h90
`define PIM_BSTAT_CLR 8'h30
`define PIM_EXPN_CLR 8'h06

// Timing figures in their own units.
`define PIM_CLK_PERIOD_NS 5
`define PIM_MS_NS 1000000
`define PIM_ACQ_MS 4
`define PIM_UNPLUG_DELAY_MS 1000
`define PIM_UNPLUG_PULSE_MS 256

`endif

// ===== hw/pim_pkg.sv
package pim_pkg;

  // Status levels reported by the transceiver core, all asynchronous here.
  typedef struct packed {
    logic neg_done;
    logic remote_fault;
    logic link_up;
    logic partner_ack;
    logic pd_fault;
    logic page_rx;
    logic renegotiate;
  } pim_phy_stat_t;

  // Software mode settings.
  typedef struct packed {
    logic edpd_en;
    logic alt_mode;
  } pim_mode_t;

  // States of the cable unplug pulse sequencer.
  typedef enum logic [2:0] {
    PIM_UP_IDLE = 3'b001,
    PIM_UP_WAIT = 3'b010,
    PIM_UP_PULSE = 3'b100
  } pim_unplug_t;

endpackage

// ===== hw/pim_sync.sv
`timescale 1ns/10ps
// Two flip-flop synchroniser for levels from outside the clock domain.
module pim_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Asynchronous level in, synchronised level out.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta;

  // Both stages clear under reset; the owner defines sane values after it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ===== hw/pim_edpd.sv
`timescale 1ns/10ps
`include "pim_params.svh"
// Energy presence filter and the delayed unplug pulse.
module pim_edpd #(
  parameter int CYC_PER_MS = `PIM_MS_NS / `PIM_CLK_PERIOD_NS,
  parameter int ACQ_MS = `PIM_ACQ_MS,
  parameter int DELAY_MS = `PIM_UNPLUG_DELAY_MS,
  parameter int PULSE_MS = `PIM_UNPLUG_PULSE_MS
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Synchronised squelch energy and the arm request from the flag logic.
  input wire logic line_energy,
  input wire logic unplug_arm,
  // Filtered energy status and the unplug pulse.
  output logic energy_present,
  output logic unplug_pulse
);

  logic [31:0] tick_cnt; // Cycles within the current millisecond.
  logic ms_tick; // One cycle per millisecond.
  logic acq_done; // Signal acquisition window has ended.
  logic [15:0] acq_cnt; // Milliseconds spent in acquisition.
  logic [15:0] up_cnt; // Milliseconds in the unplug wait or pulse.
  pim_pkg::pim_unplug_t up_state; // Unplug sequencer state.

  // Free running millisecond prescaler.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt <= 32'h0;
      ms_tick <= 1'b0;
    end else if (tick_cnt == 32'(CYC_PER_MS - 1)) begin
      tick_cnt <= 32'h0;
      ms_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      ms_tick <= 1'b0;
    end
  end

  // Energy reads as present from reset until acquisition ends, then follows the line.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acq_cnt <= 16'h0;
      acq_done <= 1'b0;
      energy_present <= 1'b1;
    end else begin
      if (ms_tick && !acq_done) begin
        acq_cnt <= acq_cnt + 16'h1;
        acq_done <= (acq_cnt == 16'(ACQ_MS - 1));
      end
      energy_present <= line_energy | ~acq_done;
    end
  end

  // Waits about a second after energy is lost, then pulses; returning energy aborts the wait.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      up_state <= pim_pkg::PIM_UP_IDLE;
      up_cnt <= 16'h0;
      unplug_pulse <= 1'b0;
    end else begin
      unique case (up_state)
        pim_pkg::PIM_UP_IDLE: begin
          up_cnt <= 16'h0;
          if (unplug_arm && !line_energy && energy_present) begin
            up_state <= pim_pkg::PIM_UP_WAIT;
          end
        end
        pim_pkg::PIM_UP_WAIT: begin
          if (line_energy) begin
            up_state <= pim_pkg::PIM_UP_IDLE;
          end else if (ms_tick) begin
            if (up_cnt == 16'(DELAY_MS - 1)) begin
              up_cnt <= 16'h0;
              unplug_pulse <= 1'b1;
              up_state <= pim_pkg::PIM_UP_PULSE;
            end else begin
              up_cnt <= up_cnt + 16'h1;
            end
          end
        end
        pim_pkg::PIM_UP_PULSE: begin
          if (ms_tick) begin
            if (up_cnt == 16'(PULSE_MS - 1)) begin
              unplug_pulse <= 1'b0;
              up_state <= pim_pkg::PIM_UP_IDLE;
            end else begin
              up_cnt <= up_cnt + 16'h1;
            end
          end
        end
        default: begin
          unplug_pulse <= 1'b0;
          up_state <= pim_pkg::PIM_UP_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== hw/pim_top.sv
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "pim_params.svh"
// How it works
// - Primary mode unless alternate bit set; reset forces primary.
// - Pin asserts only for unmasked sources with events.
// - Energy source: rise sets; fall or flag read clears.
// - Negotiation done: rise sets; fall or flag read clears.
// - Remote fault: rise sets; fall, status or flag read clears.
// - Link down: fall sets; status or flag read clears.
// - Partner acknowledge: rise sets; fall or flag read clears.
// - Detection fault: fall, expansion or flag read, renegotiation, link loss clear.
// - Page received: same releases as detection fault.
// - Energy released while present pulses after unplug.
// - Energy status and flag start at one.
// - Writing alternate bit selects alternate mode; reset loses it.
// - Alternate mode: clearing mask releases the pin at once.
// - Alternate mode: writing one rechecks the source.
// - Alternate flag clears only with source inactive.
// - Power-down enable without energy stops the transceiver.
// - Returning energy powers up and raises the energy source.
// - Interrupt pin low while asserted.
// - Mask bits seven to one, reset zero, others zero.
module pim_top #(
  parameter int CYC_PER_MS = `PIM_MS_NS / `PIM_CLK_PERIOD_NS,
  parameter int ACQ_MS = `PIM_ACQ_MS,
  parameter int DELAY_MS = `PIM_UNPLUG_DELAY_MS,
  parameter int PULSE_MS = `PIM_UNPLUG_PULSE_MS
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous status from the transceiver core.
  input wire pim_pkg::pim_phy_stat_t phy_stat,
  input wire logic line_energy,
  // Interrupt pin and power control.
  output logic irq_n_out,
  output logic phy_power_down,
  output logic tx_inhibit
);

  // Synchronised copies of the core status and line energy.
  pim_pkg::pim_phy_stat_t stat_q;
  logic line_q;

  // Software state.
  pim_pkg::pim_mode_t mode; // Mode control bits.
  logic [7:0] mask; // Source enables, bit 0 unused.
  logic [7:0] flags; // Latched source flags, bit 0 unused.

  // Source tracking.
  logic energy_present; // Filtered energy status.
  logic unplug_pulse; // Delayed pulse after a cable unplug.
  logic unplug_arm; // Energy interrupt was released while energy was present.
  logic [7:0] active; // Present level of each source, high when active.
  logic [7:0] active_d; // Active levels one cycle ago.
  logic [7:0] rise; // Assertion events.
  logic [7:0] fall; // Return to inactive.
  logic reneg_d; // Renegotiation level one cycle ago.
  logic reneg_rise; // Start of a renegotiation.

  // Bus decode.
  logic acc; // Access completes at this edge.
  logic rd; // Completing read.
  logic wr; // Completing write.
  logic [5:0] idx; // Register index from the byte address.
  logic [7:0] rd_clr; // Flags released by reads and link events.
  logic [7:0] w1_clr; // Flags released by alternate write-one.
  logic [7:0] next_flags; // Next value of the flags.

  // Returns whether an index names a mapped register.
  function automatic logic is_mapped(input logic [5:0] i);
    is_mapped = (i == `PIM_IDX_BSTAT) || (i == `PIM_IDX_LPABL) ||
                (i == `PIM_IDX_EXPN) || (i == `PIM_IDX_MODE) ||
                (i == `PIM_IDX_FLAGS) || (i == `PIM_IDX_MASK);
  endfunction

  // Builds a 32-bit word with a single bit at a position.
  function automatic logic [31:0] bit_at(input logic v, input int pos);
    bit_at = 32'(v) << pos;
  endfunction

  // Core status and energy cross into the clock domain as levels.
  pim_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({phy_stat, line_energy}),
    .q({stat_q, line_q})
  );

  // Energy filter and unplug sequencer.
  pim_edpd #(
    .CYC_PER_MS(CYC_PER_MS),
    .ACQ_MS(ACQ_MS),
    .DELAY_MS(DELAY_MS),
    .PULSE_MS(PULSE_MS)
  ) u_edpd (
    .clk_sys(clk_sys),
    .rst(rst),
    .line_energy(line_q),
    .unplug_arm(unplug_arm),
    .energy_present(energy_present),
    .unplug_pulse(unplug_pulse)
  );

  // Active levels; the link source is active while the link is down.
  always_comb begin
    active = 8'h00;
    active[`PIM_SRC_ENERGY] = energy_present;
    active[`PIM_SRC_NEGDONE] = stat_q.neg_done;
    active[`PIM_SRC_RFAULT] = stat_q.remote_fault;
    active[`PIM_SRC_LINKDN] = ~stat_q.link_up;
    active[`PIM_SRC_PACK] = stat_q.partner_ack;
    active[`PIM_SRC_PDF] = stat_q.pd_fault;
    active[`PIM_SRC_PAGE] = stat_q.page_rx;
  end

  // Previous levels for edge detection; reset matches the reset state of the sources.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      active_d <= `PIM_ACT_RST;
      reneg_d <= 1'b0;
    end else begin
      active_d <= active;
      reneg_d <= stat_q.renegotiate;
    end
  end

  // Events are the same in both modes; the link down event is a falling link.
  assign rise = active & ~active_d & `PIM_SRC_BITS;
  assign fall = ~active & active_d & `PIM_SRC_BITS;
  assign reneg_rise = stat_q.renegotiate & ~reneg_d;

  // An access completes at the edge where the registered ready is high.
  assign acc = psel & penable & pready;
  assign rd = acc & ~pwrite;
  assign wr = acc & pwrite;
  assign idx = paddr[7:2];

  // Releases caused by register reads, renegotiation and link loss.
  always_comb begin
    rd_clr = 8'h00;
    if (rd && idx == `PIM_IDX_FLAGS) begin
      rd_clr = `PIM_SRC_BITS;
    end
    if (rd && idx == `PIM_IDX_BSTAT) begin
      rd_clr = rd_clr | `PIM_BSTAT_CLR;
    end
    if ((rd && idx == `PIM_IDX_EXPN) || reneg_rise || rise[`PIM_SRC_LINKDN]) begin
      rd_clr = rd_clr | `PIM_EXPN_CLR;
    end
  end

  // Alternate mode: a one written to a flag clears it only if the source is inactive.
  assign w1_clr = (wr && idx == `PIM_IDX_FLAGS) ? (pwdata[7:0] & ~active) : 8'h00;

  // Flag update; a new event in the clearing cycle wins over the clear.
  always_comb begin
    if (mode.alt_mode) begin
      next_flags = (flags & ~w1_clr) | rise;
    end else begin
      // The link down flag is not released by the link coming back.
      next_flags = (flags & ~(rd_clr | (fall & ~`PIM_BSTAT_CLR & ~8'h10) |
                   (fall & 8'h20))) | rise;
    end
    next_flags = next_flags & `PIM_SRC_BITS;
  end

  // The energy flag starts set, matching the energy status default.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags <= `PIM_FLAG_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // Mode bits; reset always returns to primary mode with power-down disabled.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode <= '0;
    end else if (wr && idx == `PIM_IDX_MODE) begin
      mode.alt_mode <= pwdata[`PIM_MD_ALT];
      mode.edpd_en <= pwdata[`PIM_MD_EDPD];
    end
  end

  // Mask register; only bits seven to one are kept.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask <= `PIM_MASK_RST;
    end else if (wr && idx == `PIM_IDX_MASK) begin
      mask <= pwdata[7:0] & `PIM_SRC_BITS;
    end
  end

  // Arms the unplug pulse when the energy flag is released by a read while
  // energy is still present and the source is enabled. Software avoids the
  // late pulse by clearing that mask bit in its service routine.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      unplug_arm <= 1'b0;
    end else if (!mask[`PIM_SRC_ENERGY] || !energy_present) begin
      unplug_arm <= 1'b0;
    end else if (!mode.alt_mode && rd_clr[`PIM_SRC_ENERGY] && flags[`PIM_SRC_ENERGY] &&
                 !rise[`PIM_SRC_ENERGY]) begin
      unplug_arm <= 1'b1;
    end
  end

  // Interrupt pin, low while any enabled flag is set or the unplug pulse runs with the energy source enabled.
  // The mask gates directly, so clearing a mask bit releases the pin at once.
  // Registered so the pin is glitch free; it still changes without any bus edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_n_out <= 1'b1;
    end else begin
      irq_n_out <= ~(|(next_flags & mask) |
                   (unplug_pulse & mask[`PIM_SRC_ENERGY]));
    end
  end

  // Energy detect power-down: everything but management stops while no energy.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phy_power_down <= 1'b0;
      tx_inhibit <= 1'b0;
    end else begin
      phy_power_down <= mode.edpd_en & ~energy_present;
      tx_inhibit <= mode.edpd_en & ~energy_present;
    end
  end

  // APB ready is registered, so every transfer has exactly one wait state.
  // Read data and the error flag are captured alongside it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~is_mapped(idx);
      unique case (idx)
        `PIM_IDX_BSTAT: begin
          prdata <= bit_at(stat_q.neg_done, `PIM_BS_NEGDONE) |
                    bit_at(stat_q.remote_fault, `PIM_BS_RFAULT) |
                    bit_at(stat_q.link_up, `PIM_BS_LINK);
        end
        `PIM_IDX_LPABL: begin
          prdata <= bit_at(stat_q.partner_ack, `PIM_LP_ACK);
        end
        `PIM_IDX_EXPN: begin
          prdata <= bit_at(stat_q.pd_fault, `PIM_EX_PDF) |
                    bit_at(stat_q.page_rx, `PIM_EX_PAGE);
        end
        `PIM_IDX_MODE: begin
          prdata <= bit_at(mode.edpd_en, `PIM_MD_EDPD) |
                    bit_at(mode.alt_mode, `PIM_MD_ALT) |
                    bit_at(energy_present, `PIM_MD_ENERGY);
        end
        `PIM_IDX_FLAGS: begin
          prdata <= {24'h0, flags}; // Reserved bits read as zero.
        end
        `PIM_IDX_MASK: begin
          prdata <= {24'h0, mask};
        end
        default: begin
          prdata <= 32'h0;
        end
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
  end

endmodule

// ===== dv/pim_top_checker.sv
`timescale 1ns/10ps
// Watches the slave bus, the interrupt pin and the power outputs of the block.
module pim_top_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and power control.
  input wire logic irq_n_out,
  input wire logic phy_power_down,
  input wire logic tx_inhibit
);
  logic [5:0] idx; // Word index of the current transfer.
  logic mapped; // High when the index names a register.
  logic [7:0] mask_sh; // Mask as last written by software.
  logic edpd_sh; // Power-down enable as last written.
  assign idx = paddr[7:2];
  assign mapped = idx inside {6'h01, 6'h05, 6'h06, 6'h11, 6'h1d, 6'h1e};
  // Shadows follow completed writes, so the pin is judged without internal state.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_sh <= 8'h00;
      edpd_sh <= 1'b0;
    end else if (psel && penable && pready && pwrite && mapped) begin
      if (idx == 6'h1e) begin
        mask_sh <= pwdata[7:0] & 8'hfe;
      end
      if (idx == 6'h11) begin
        edpd_sh <= pwdata[13];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property (disable iff (1'b0) rst |-> irq_n_out && !pready)
    else $error("pin or ready active in reset");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_idle_data: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  a_unmapped_err: assert property (pready |-> pslverr == !mapped) else $error("wrong error answer");
  a_reserved_zero: assert property (pready && !pwrite && idx inside {6'h1d, 6'h1e} |->
    prdata[31:8] == 24'h0 && !prdata[0]) else $error("reserved bits not zero");
  a_mask_readback: assert property (pready && !pwrite && idx == 6'h1e |->
    prdata[7:0] == mask_sh) else $error("mask reads back wrong");
  a_masked_quiet: assert property (mask_sh == 8'h00 && $past(mask_sh) == 8'h00 |->
    irq_n_out) else $error("pin low with every source masked");
  a_edpd_off: assert property (!edpd_sh && !$past(edpd_sh) |-> !phy_power_down)
    else $error("power down while disabled");
  a_tx_quiet: assert property (phy_power_down |-> tx_inhibit) else $error("transmit while down");
  c_error: cover property (pready && pslverr);
  c_irq: cover property ($fell(irq_n_out));
  c_down: cover property ($rose(phy_power_down));
  c_alt: cover property (pready && pwrite && idx == 6'h11 && pwdata[6]);
endmodule

bind pim_top pim_top_checker chk_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_n_out(irq_n_out),
  .phy_power_down(phy_power_down), .tx_inhibit(tx_inhibit));

// ===== dv/pim_apb_master.sv
`timescale 1ns/10ps
// Management controller that reaches the registers through APB transfers.
module pim_apb_master (
  // Clock.
  input wire logic clk_sys,
  // Request side.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer side.
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer, entered at a rising edge; ok stays low if the slave never answers.
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    err = 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) begin
        ok = 1'b1;
        rd = prdata;
        err = pslverr;
      end
    end
    // Released lines change so that a stale value is never mistaken for a live one.
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
    @(posedge clk_sys);
  endtask
endmodule

// ===== dv/pim_top_bench.sv
`timescale 1ns/10ps
`include "pim_params.svh"
// Register-level tests of the interrupt block with shortened millisecond counts.
module pim_top_bench;
  localparam int CPM = 20; // Cycles per millisecond in simulation.
  localparam int ACQ = 2;
  localparam int DLY = 3;
  localparam int PLS = 2;
  logic clk_sys = 1'b0;
  logic rst = 1'b0; // Raised at time zero so the asynchronous reset sees an edge.
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  pim_pkg::pim_phy_stat_t phy_stat = 7'b0010000; // Link up, all else quiet.
  logic line_energy = 1'b0;
  logic irq_n_out, phy_power_down, tx_inhibit, rerr;
  int fails = 0;
  int total_checks = 0;
  int i, n;
  always #2.5 clk_sys = ~clk_sys;
  pim_apb_master mst_u (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pim_top #(.CYC_PER_MS(CPM), .ACQ_MS(ACQ), .DELAY_MS(DLY), .PULSE_MS(PLS)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_stat(phy_stat), .line_energy(line_energy), .irq_n_out(irq_n_out),
    .phy_power_down(phy_power_down), .tx_inhibit(tx_inhibit));
  // Compares and counts; four-state equality so an unknown never matches.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // A transfer whose missing answer ends the run.
  task automatic acc(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    logic ok;
    mst_u.xfer(wr, idx, wd, rv, rerr, ok);
    if (!ok) begin
      fails++;
      test_done();
    end
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    acc(1'b0, idx, 32'h0);
    chk(rv, exp);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic pin(input logic e);
    chk({31'h0, irq_n_out}, {31'h0, e});
  endtask
  // Toggles one status level and lets it pass the synchroniser.
  task automatic flip(input int b);
    phy_stat <= phy_stat ^ (7'h01 << b);
    tick(8);
  endtask
  // Counts cycles while the pin holds a level; a hang ends the run.
  task automatic hold(input logic lvl, output int c);
    for (c = 0; c < 400 && irq_n_out === lvl; c++) tick(1);
    if (c >= 400) begin
      fails++;
      test_done();
    end
  endtask
  initial begin
    rst <= 1'b1;
    tick(10);
    rst <= 1'b0;
    tick(1);
    rd(`PIM_IDX_MODE, 32'h2);
    rd(`PIM_IDX_MASK, 32'h0);
    rd(`PIM_IDX_FLAGS, 32'h80);
    pin(1'b1);
    rd(6'h02, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    tick(ACQ * CPM + 20);
    rd(`PIM_IDX_MODE, 32'h0);
    $display("test reset done");
    // Each source sets, then only its own registers clear it.
    acc(1'b1, `PIM_IDX_MASK, 32'hfe);
    for (i = 6; i >= 1; i--) begin
      flip(i);
      pin(1'b0);
      acc(1'b0, (i < 3) ? `PIM_IDX_EXPN : `PIM_IDX_BSTAT, 32'h0);
      rd(`PIM_IDX_FLAGS, (i == 5 || i == 4 || i < 3) ? 32'h0 : 32'h1 << i);
      flip(i);
      rd(`PIM_IDX_FLAGS, 32'h0);
      pin(1'b1);
    end
    // A falling source releases its flag, link down excepted.
    for (i = 6; i >= 1; i--) begin
      flip(i);
      flip(i);
      rd(`PIM_IDX_FLAGS, (i == 4) ? 32'h10 : 32'h0);
    end
    flip(1);
    flip(0);
    rd(`PIM_IDX_FLAGS, 32'h0);
    flip(0);
    flip(1);
    flip(2);
    flip(4);
    rd(`PIM_IDX_FLAGS, 32'h10);
    flip(4);
    flip(2);
    acc(1'b1, `PIM_IDX_MASK, 32'h40);
    flip(3);
    pin(1'b1);
    rd(`PIM_IDX_FLAGS, 32'h08);
    flip(3);
    $display("test primary done");
    // Power-down without energy, wake-up, then the delayed unplug pulse.
    acc(1'b1, `PIM_IDX_MODE, 32'h2000);
    acc(1'b1, `PIM_IDX_MASK, 32'h80);
    tick(4);
    chk({31'h0, phy_power_down}, 32'h1);
    chk({31'h0, tx_inhibit}, 32'h1);
    rd(`PIM_IDX_MODE, 32'h2000);
    line_energy <= 1'b1;
    tick(8);
    pin(1'b0);
    chk({31'h0, phy_power_down}, 32'h0);
    chk({31'h0, tx_inhibit}, 32'h0);
    rd(`PIM_IDX_MODE, 32'h2002);
    rd(`PIM_IDX_FLAGS, 32'h80);
    pin(1'b1);
    line_energy <= 1'b0;
    hold(1'b1, n);
    // The wait counts whole prescaler milliseconds, so the first one may be short.
    chk({31'h0, n >= (DLY - 1) * CPM && n <= DLY * CPM + 8}, 32'h1);
    hold(1'b0, n);
    chk({31'h0, n >= PLS * CPM - 2 && n <= PLS * CPM + 2}, 32'h1);
    acc(1'b1, `PIM_IDX_MASK, 32'h0);
    $display("test energy done");
    // Alternate mode: only a write of one with the source inactive clears.
    acc(1'b1, `PIM_IDX_MODE, 32'h40);
    acc(1'b1, `PIM_IDX_MASK, 32'hfe);
    flip(6);
    acc(1'b1, `PIM_IDX_FLAGS, 32'h40);
    rd(`PIM_IDX_FLAGS, 32'h40);
    pin(1'b0);
    flip(6);
    rd(`PIM_IDX_FLAGS, 32'h40);
    acc(1'b1, `PIM_IDX_FLAGS, 32'h40);
    rd(`PIM_IDX_FLAGS, 32'h0);
    pin(1'b1);
    flip(4);
    acc(1'b1, `PIM_IDX_FLAGS, 32'h10);
    rd(`PIM_IDX_FLAGS, 32'h10);
    acc(1'b1, `PIM_IDX_MASK, 32'h0);
    tick(1);
    pin(1'b1);
    rd(`PIM_IDX_FLAGS, 32'h10);
    flip(4);
    acc(1'b1, `PIM_IDX_FLAGS, 32'h10);
    rd(`PIM_IDX_FLAGS, 32'h0);
    $display("test alternate done");
    // A second reset drops the alternate mode; the mask was already cleared by software before it.
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(1);
    rd(`PIM_IDX_MODE, 32'h2);
    rd(`PIM_IDX_MASK, 32'h0);
    pin(1'b1);
    $display("test reset again done");
    test_done();
  end
endmodule
